// >>> test/fpg_stage.sv
// Power-stage model: per-cycle overcurrent reports and soft-start ramp
`timescale 1ns/10ps
`default_nettype none
module fpg_stage (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic oc,
  output var fpg_pkg::fpg_cycle_t cyc,
  output logic done
);
  logic [2:0] ph_reg;
  logic [4:0] ramp_reg;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ph_reg <= 3'h0;
      ramp_reg <= 5'h00;
    end
    else
    begin
      ph_reg <= ph_reg + 3'h1;
      ramp_reg <= !run ? 5'h00 : ramp_reg + {4'h0, ~&ramp_reg};
    end
  end
  assign cyc = '{ph_reg == 3'h7, oc && ph_reg == 3'h7, 1'b0, 1'b0};
  // Ramp saturates, so done stays up while running
  assign done = &ramp_reg;
endmodule
`default_nettype wire

// >>> test/fpg_supervisor_assertions.sv
// Port-level assertions for the fault supervisor
`timescale 1ns/10ps
`default_nettype none
module fpg_supervisor_assertions #(
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic pslverr,
  input wire logic die_over_temp,
  input wire logic hs_fet_enable,
  input wire logic ls_fet_enable,
  input wire logic ls_force_on,
  input wire logic soft_start_run,
  input wire logic [1:0] high_side_current_limit_trim,
  input wire logic power_good_out_o,
  input wire logic power_good_out_oe,
  input wire logic smbalert_o
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_rise_pg_low: assert property (
    soft_start_run |-> hs_fet_enable && power_good_out_oe) else $error("pg up in rise");
  a_pg_release: assert property (
    $fell(power_good_out_oe) |-> $past(hs_fet_enable && !soft_start_run))
    else $error("pg released outside run");
  a_fets_off_pg: assert property (
    !hs_fet_enable && !$past(hs_fet_enable) |-> power_good_out_oe)
    else $error("pg high with fets off");
  a_od_drive: assert property (
    power_good_out_o == 1'b0 && smbalert_o == 1'b0) else $error("open drain drives high");
  a_err_access: assert property (
    pslverr |-> psel && penable) else $error("error outside access");
  a_ls_force_hs: assert property (
    ls_force_on |-> !hs_fet_enable && !ls_fet_enable) else $error("hs on in discharge");
  a_fets_pair: assert property (
    hs_fet_enable == ls_fet_enable && (!$rose(hs_fet_enable) || soft_start_run))
    else $error("fets on without soft start");
  a_die_ot_stop: assert property (
    die_over_temp [*6] |=> !hs_fet_enable) else $error("die hot, fets on");
  a_trim_write: assert property (
    $changed(high_side_current_limit_trim)
    |-> $past(psel && penable && pwrite && paddr == fpg_pkg::OFS_TRIM))
    else $error("trim changed without write");
endmodule
bind fpg_supervisor fpg_supervisor_assertions #(.AW(AW)) u_chk (.clk(clk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pslverr(pslverr), .die_over_temp(die_over_temp), .hs_fet_enable(hs_fet_enable),
  .ls_fet_enable(ls_fet_enable), .ls_force_on(ls_force_on),
  .soft_start_run(soft_start_run),
  .high_side_current_limit_trim(high_side_current_limit_trim),
  .power_good_out_o(power_good_out_o), .power_good_out_oe(power_good_out_oe),
  .smbalert_o(smbalert_o));
`default_nettype wire

// >>> test/fpg_supervisor_tb.sv
// Self-checking bench for the fault supervisor
`timescale 1ns/10ps
`default_nettype none
module fpg_supervisor_tb;
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic die = 1'b0, on = 1'b0, oc = 1'b0, err, done;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
  logic [15:0] vout = 16'h0000;
  logic [11:0] temp = 12'h019;
  logic pready, pslverr, hs, ls, lsf, ssr, pgo, pgoe, alo, aloe;
  logic [1:0] trim;
  fpg_pkg::fpg_cycle_t cyc;
  int error_cnt = 0, num_checks = 0;
  // Board pull-up on the power-good pin
  wire logic pg = pgoe ? pgo : 1'b1;
  fpg_supervisor dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense({vout, temp}), .cycle(cyc), .soft_start_done(done),
    .die_over_temp(die), .converter_on_off_control(on), .hs_fet_enable(hs),
    .ls_fet_enable(ls), .ls_force_on(lsf), .soft_start_run(ssr),
    .high_side_current_limit_trim(trim), .power_good_out_o(pgo),
    .power_good_out_oe(pgoe), .smbalert_o(alo), .smbalert_oe(aloe));
  fpg_stage stage (.clk(clk), .reset_n(reset_n), .run(hs), .oc(oc), .cyc(cyc),
    .done(done));
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Counts PWM cycle reports with the overcurrent request held
  task automatic pwm(input int n, input logic o);
    oc <= o;
    repeat (n)
    begin
      @(posedge clk);
      while (!cyc.cycle_end) @(posedge clk);
    end
  endtask
  task automatic wfet(input logic e, input int lim);
    for (int i = 0; i < lim && hs !== e; i++) @(posedge clk);
    chk("fet", e, hs);
  endtask
  task automatic wpg;
    for (int i = 0; i < 3000 && pgoe !== 1'b0; i++) @(posedge clk);
    chk("pg", 1, pg);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(6));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    xfer(0, fpg_pkg::OFS_RESP, 0);
    chk("resp", {24'h0, fpg_pkg::RESP_RST}, rd);
    xfer(0, fpg_pkg::OFS_OV_WARN, 0);
    chk("ovw", {16'h0, fpg_pkg::OV_WARN_RST}, rd);
    xfer(0, fpg_pkg::OFS_UV_WARN, 0);
    chk("uvw", {16'h0, fpg_pkg::UV_WARN_RST}, rd);
    xfer(0, 8'h3C, 0);
    chk("unmapped", 32'h0000_0001, {rd[30:0], err});
    $display("test regs done");
    xfer(1, fpg_pkg::OFS_TON_RISE, 32'h0000_0001);
    vout <= 16'h8000;
    on <= 1'b1;
    wpg();
    repeat (16)
    begin
      vout <= 16'h4100 + 16'($urandom % 32'h0000_7D00);
      repeat (4) @(posedge clk);
      chk("pg in window", 1, pg);
    end
    vout <= 16'hD000;
    repeat (4) @(posedge clk);
    chk("pg over warn", 0, pg);
    chk("fet warn", 1, hs);
    xfer(1, fpg_pkg::OFS_SCALE, 32'h0000_0001);
    vout <= 16'hBFA0;
    repeat (8) @(posedge clk);
    chk("pg in hyst", 0, pg);
    vout <= 16'hBF60;
    repeat (8) @(posedge clk);
    chk("pg past hyst", 1, pg);
    chk("alert", 1, aloe);
    xfer(1, fpg_pkg::OFS_MASK, 32'h0000_03FF);
    chk("alert masked", 0, aloe);
    xfer(1, fpg_pkg::OFS_MASK, 0);
    xfer(1, fpg_pkg::OFS_STATUS, 32'h0000_03FF);
    chk("alert cleared", 0, aloe);
    xfer(1, fpg_pkg::OFS_TRIM, 32'h0000_0003);
    chk("trim", 3, trim);
    $display("test window done");
    xfer(1, fpg_pkg::OFS_RESP, 32'h0000_0059);
    pwm(4, 1);
    pwm(1, 0);
    chk("oc ignore", 3, {hs, pg});
    xfer(1, fpg_pkg::OFS_RESP, 32'h0000_0051);
    pwm(2, 1);
    pwm(1, 0);
    pwm(2, 1);
    chk("oc two", 1, hs);
    pwm(1, 1);
    repeat (3) @(posedge clk);
    chk("oc latch", 0, {hs, pg});
    oc <= 1'b0;
    repeat (2000) @(posedge clk);
    chk("latch held", 0, hs);
    xfer(1, fpg_pkg::OFS_CTRL, 32'h0000_0001);
    wfet(1, 200);
    wpg();
    xfer(1, fpg_pkg::OFS_RESP, 32'h0000_0055);
    pwm(3, 1);
    pwm(1, 0);
    chk("hiccup", 0, hs);
    repeat (1650) @(posedge clk);
    chk("hiccup wait", 0, hs);
    wfet(1, 300);
    $display("test overcurrent done");
    wpg();
    temp <= 12'h07E;
    repeat (8) @(posedge clk);
    chk("ot trip", 0, {hs, pg});
    temp <= 12'h06D;
    repeat (50) @(posedge clk);
    chk("ot cooling", 0, hs);
    temp <= 12'h068;
    wfet(1, 100);
    repeat (100) @(posedge clk);
    chk("ot warn pg", 0, pg);
    temp <= 12'h019;
    xfer(1, fpg_pkg::OFS_RESP, 32'h0000_0056);
    die <= 1'b1;
    repeat (10) @(posedge clk);
    chk("die ot", 0, hs);
    die <= 1'b0;
    wfet(1, 200);
    wpg();
    temp <= 12'h07E;
    repeat (8) @(posedge clk);
    chk("ot ignore", 3, {hs, pg});
    temp <= 12'h019;
    $display("test temperature done");
    wpg();
    xfer(1, fpg_pkg::OFS_RESP, 32'h0000_0016);
    vout <= 16'h1000;
    repeat (6) @(posedge clk);
    chk("uv latch", 0, {hs, pg});
    on <= 1'b0;
    vout <= 16'h8000;
    repeat (8) @(posedge clk);
    on <= 1'b1;
    wfet(1, 100);
    wpg();
    xfer(1, fpg_pkg::OFS_RESP, 32'h0000_0046);
    vout <= 16'hF000;
    repeat (6) @(posedge clk);
    chk("ov action", 1, {hs, lsf});
    $display("test voltage faults done");
    close_out();
  end
  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire

// >>> verilog/fpg_pkg.sv
// Shared constants, register map and carrier types for the fault supervisor
package fpg_pkg;

  // Data widths
  localparam int VW = 16;
  localparam int TW = 12;
  localparam int STAT_W = 10;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RESP = 8'h04;
  localparam logic [7:0] OFS_OV_WARN = 8'h08;
  localparam logic [7:0] OFS_UV_WARN = 8'h0C;
  localparam logic [7:0] OFS_OV_FAULT = 8'h10;
  localparam logic [7:0] OFS_UV_FAULT = 8'h14;
  localparam logic [7:0] OFS_OT_FAULT = 8'h18;
  localparam logic [7:0] OFS_OT_WARN = 8'h1C;
  localparam logic [7:0] OFS_SCALE = 8'h20;
  localparam logic [7:0] OFS_TRIM = 8'h24;
  localparam logic [7:0] OFS_MASK = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_STATE = 8'h30;
  localparam logic [7:0] OFS_TON_RISE = 8'h34;

  // Field positions
  localparam int CTRL_CLEAR = 0;
  localparam int CTRL_OV_SEL = 1;
  localparam int RESP_OT = 0;
  localparam int RESP_OC = 2;
  localparam int RESP_OV = 4;
  localparam int RESP_UV = 6;

  // Response codes
  localparam logic [1:0] RESP_LATCH = 2'h0;
  localparam logic [1:0] RESP_RESTART = 2'h1;
  localparam logic [1:0] RESP_IGNORE = 2'h2;

  // Status bit positions
  localparam int ST_EXT_OTF = 0;
  localparam int ST_EXT_OTW = 1;
  localparam int ST_INT_OTF = 2;
  localparam int ST_LS_OCF = 3;
  localparam int ST_HS_OCF = 4;
  localparam int ST_OVF = 5;
  localparam int ST_OVW = 6;
  localparam int ST_UVF = 7;
  localparam int ST_UVW = 8;
  localparam int ST_LS_OCW = 9;

  // Values after reset, and hysteresis base
  localparam logic [7:0] RESP_RST = 8'h55;
  localparam logic [VW-1:0] OV_WARN_RST = 16'hC000;
  localparam logic [VW-1:0] UV_WARN_RST = 16'h4000;
  localparam logic [VW-1:0] OV_FAULT_RST = 16'hE000;
  localparam logic [VW-1:0] UV_FAULT_RST = 16'h2000;
  localparam logic [TW-1:0] OT_FAULT_RST = 12'h07D;
  localparam logic [TW-1:0] OT_WARN_RST = 12'h064;
  localparam logic [15:0] TON_RISE_RST = 16'h0BB8;
  localparam logic [VW-1:0] HYST_BASE = 16'h0040;

  // Timing: cooling margin in degrees (one per LSB), hiccup in rise times
  localparam logic [TW-1:0] OT_COOL_DEG = 12'h014;
  localparam int OC_TRIP_COUNT = 3;
  localparam int HICCUP_RISES = 7;
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_US = 1000;
  localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;

  // Digitised sense values from the converter front end
  typedef struct packed {
    logic [VW-1:0] vout;
    logic [TW-1:0] temp;
  } fpg_sense_t;

  // Per switching cycle overcurrent report
  typedef struct packed {
    logic cycle_end;
    logic hs_oc;
    logic ls_oc;
    logic ls_oc_warn;
  } fpg_cycle_t;

endpackage

// >>> verilog/fpg_supervisor.sv
// Fault response, power-good and alert logic of a buck converter controller
// How it works
// - Release power-good only inside window after start-up
// - Window bounded by programmable OV/UV warn limits
// - Hysteresis doubles each time loop scale halves
// - Any active fault pulls power-good low, except external OT or overcurrent set to ignore
// - External OT response: latch, restart, or ignore
// - External OT restart only after 20 degrees cooling
// - Die over-temperature always stops, restarts when cool
// - Overcurrent latch-off after three counts, FETs off
// - Overcurrent restart after seven rise-time hiccup
// - HS overcurrent ignore keeps peak limit, trim field
// - LS overcurrent ignore keeps PWM, power-good high
// - OV: high side off, low side per select
// - OV restart discharges, waits seven rises, PG low
// - Warnings and ignored OV keep PWM running
// - All conditions but UV fault active in rise, alert maskable
// - Three consecutive overcurrent cycles invoke response
// - Hiccup waits seven rises then soft-starts again
// - UV fault latch or restart, both FETs off
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module fpg_supervisor #(
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fpg_pkg::fpg_sense_t sense,
  input wire fpg_pkg::fpg_cycle_t cycle,
  input wire logic soft_start_done,
  input wire logic die_over_temp,
  input wire logic converter_on_off_control,
  output logic hs_fet_enable,
  output logic ls_fet_enable,
  output logic ls_force_on,
  output logic soft_start_run,
  output logic [1:0] high_side_current_limit_trim,
  output logic power_good_out_o,
  output logic power_good_out_oe,
  output logic smbalert_o,
  output logic smbalert_oe
);

  typedef enum logic [2:0] {S_OFF, S_RISE, S_RUN, S_HICCUP, S_COOL, S_LATCH} fpg_state_t;

  localparam int VW = fpg_pkg::VW;
  localparam int TW = fpg_pkg::TW;
  localparam int SW = fpg_pkg::STAT_W;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [1:0] pins_s;
  logic die_ot;
  logic on_ctrl;

  fpg_sync3 #(.W(2)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .din({die_over_temp, converter_on_off_control}),
    .dout(pins_s)
  );

  assign die_ot = pins_s[1];
  assign on_ctrl = pins_s[0];

  //////////////////////////////////////////////////////////////////////////////
  // APB register file

  logic ov_sel_reg, ov_sel_next;
  logic [7:0] resp_reg, resp_next;
  logic [VW-1:0] ov_warn_reg, ov_warn_next, uv_warn_reg, uv_warn_next;
  logic [VW-1:0] ov_fault_reg, ov_fault_next, uv_fault_reg, uv_fault_next;
  logic [TW-1:0] ot_fault_reg, ot_fault_next, ot_warn_reg, ot_warn_next;
  logic [1:0] scale_reg, scale_next, trim_reg, trim_next;
  logic [SW-1:0] mask_reg, mask_next, status_reg, status_next, cond;
  logic [15:0] ton_rise_reg, ton_rise_next;
  logic [31:0] prdata_reg, prdata_next;
  logic clear_pulse;
  logic wr_en;
  logic mapped;
  fpg_state_t state_reg, state_next;
  logic pg_win_reg, pg_win_next, pg_pull_reg, pg_pull_next;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;

  always_comb
  begin
    ov_sel_next = ov_sel_reg;
    resp_next = resp_reg;
    ov_warn_next = ov_warn_reg;
    uv_warn_next = uv_warn_reg;
    ov_fault_next = ov_fault_reg;
    uv_fault_next = uv_fault_reg;
    ot_fault_next = ot_fault_reg;
    ot_warn_next = ot_warn_reg;
    scale_next = scale_reg;
    trim_next = trim_reg;
    mask_next = mask_reg;
    ton_rise_next = ton_rise_reg;
    clear_pulse = 1'b0;
    prdata_next = prdata_reg;
    mapped = 1'b1;
    status_next = status_reg;
    if (wr_en && paddr == AW'(fpg_pkg::OFS_STATUS))
      status_next = status_reg & ~pwdata[SW-1:0];
    status_next = status_next | cond;
    case (paddr)
      AW'(fpg_pkg::OFS_CTRL):
      begin
        prdata_next = {30'h0, ov_sel_reg, 1'b0};
        if (wr_en)
        begin
          ov_sel_next = pwdata[fpg_pkg::CTRL_OV_SEL];
          clear_pulse = pwdata[fpg_pkg::CTRL_CLEAR];
        end
      end
      AW'(fpg_pkg::OFS_RESP):
      begin
        prdata_next = {24'h0, resp_reg};
        if (wr_en)
          resp_next = pwdata[7:0];
      end
      AW'(fpg_pkg::OFS_OV_WARN):
      begin
        prdata_next = {16'h0, ov_warn_reg};
        if (wr_en)
          ov_warn_next = pwdata[VW-1:0];
      end
      AW'(fpg_pkg::OFS_UV_WARN):
      begin
        prdata_next = {16'h0, uv_warn_reg};
        if (wr_en)
          uv_warn_next = pwdata[VW-1:0];
      end
      AW'(fpg_pkg::OFS_OV_FAULT):
      begin
        prdata_next = {16'h0, ov_fault_reg};
        if (wr_en)
          ov_fault_next = pwdata[VW-1:0];
      end
      AW'(fpg_pkg::OFS_UV_FAULT):
      begin
        prdata_next = {16'h0, uv_fault_reg};
        if (wr_en)
          uv_fault_next = pwdata[VW-1:0];
      end
      AW'(fpg_pkg::OFS_OT_FAULT):
      begin
        prdata_next = {20'h0, ot_fault_reg};
        if (wr_en)
          ot_fault_next = pwdata[TW-1:0];
      end
      AW'(fpg_pkg::OFS_OT_WARN):
      begin
        prdata_next = {20'h0, ot_warn_reg};
        if (wr_en)
          ot_warn_next = pwdata[TW-1:0];
      end
      AW'(fpg_pkg::OFS_SCALE):
      begin
        prdata_next = {30'h0, scale_reg};
        if (wr_en)
          scale_next = pwdata[1:0];
      end
      AW'(fpg_pkg::OFS_TRIM):
      begin
        prdata_next = {30'h0, trim_reg};
        if (wr_en)
          trim_next = pwdata[1:0];
      end
      AW'(fpg_pkg::OFS_MASK):
      begin
        prdata_next = {22'h0, mask_reg};
        if (wr_en)
          mask_next = pwdata[SW-1:0];
      end
      AW'(fpg_pkg::OFS_STATUS):
        prdata_next = {22'h0, status_reg};
      AW'(fpg_pkg::OFS_STATE):
        prdata_next = {24'h0, pg_pull_reg, pg_win_reg, ls_force_on, 2'h0, state_reg};
      AW'(fpg_pkg::OFS_TON_RISE):
      begin
        prdata_next = {16'h0, ton_rise_reg};
        if (wr_en)
          ton_rise_next = pwdata[15:0];
      end
      default:
      begin
        prdata_next = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
    // Read data is captured in setup so it is stable through access
    if (!(psel && !penable))
      prdata_next = prdata_reg;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ov_sel_reg <= 1'b0;
      resp_reg <= fpg_pkg::RESP_RST;
      ov_warn_reg <= fpg_pkg::OV_WARN_RST;
      uv_warn_reg <= fpg_pkg::UV_WARN_RST;
      ov_fault_reg <= fpg_pkg::OV_FAULT_RST;
      uv_fault_reg <= fpg_pkg::UV_FAULT_RST;
      ot_fault_reg <= fpg_pkg::OT_FAULT_RST;
      ot_warn_reg <= fpg_pkg::OT_WARN_RST;
      scale_reg <= 2'h0;
      trim_reg <= 2'h0;
      mask_reg <= '0;
      status_reg <= '0;
      ton_rise_reg <= fpg_pkg::TON_RISE_RST;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ov_sel_reg <= ov_sel_next;
      resp_reg <= resp_next;
      ov_warn_reg <= ov_warn_next;
      uv_warn_reg <= uv_warn_next;
      ov_fault_reg <= ov_fault_next;
      uv_fault_reg <= uv_fault_next;
      ot_fault_reg <= ot_fault_next;
      ot_warn_reg <= ot_warn_next;
      scale_reg <= scale_next;
      trim_reg <= trim_next;
      mask_reg <= mask_next;
      status_reg <= status_next;
      ton_rise_reg <= ton_rise_next;
      prdata_reg <= prdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Condition detection

  logic [1:0] r_ot, r_oc, r_ov, r_uv;
  logic ext_otf, ext_otw, ovf, overvoltage_warn_level, uvf, undervoltage_warn_level, cool_ok, oc_hit, oc_trip;
  logic [1:0] oc_cnt_reg, oc_cnt_next;
  logic [VW+1:0] hyst, win_hi, win_lo, vx;

  assign r_ot = resp_reg[fpg_pkg::RESP_OT +: 2];
  assign r_oc = resp_reg[fpg_pkg::RESP_OC +: 2];
  assign r_ov = resp_reg[fpg_pkg::RESP_OV +: 2];
  assign r_uv = resp_reg[fpg_pkg::RESP_UV +: 2];
  assign ext_otf = sense.temp >= ot_fault_reg;
  assign ext_otw = sense.temp >= ot_warn_reg;
  assign cool_ok = ({1'b0, sense.temp} + {1'b0, fpg_pkg::OT_COOL_DEG}) <= {1'b0, ot_fault_reg};
  assign ovf = sense.vout > ov_fault_reg;
  assign overvoltage_warn_level = sense.vout > ov_warn_reg;
  assign undervoltage_warn_level = sense.vout < uv_warn_reg;
  // Undervoltage fault is only judged once soft-start is over
  assign uvf = (sense.vout < uv_fault_reg) && state_reg == S_RUN;
  assign oc_hit = cycle.cycle_end && (cycle.hs_oc || cycle.ls_oc);
  assign oc_trip = oc_hit && oc_cnt_reg == 2'(fpg_pkg::OC_TRIP_COUNT - 1);

  always_comb
  begin
    cond = '0;
    cond[fpg_pkg::ST_EXT_OTF] = ext_otf;
    cond[fpg_pkg::ST_EXT_OTW] = ext_otw;
    cond[fpg_pkg::ST_INT_OTF] = die_ot;
    cond[fpg_pkg::ST_LS_OCF] = oc_trip && cycle.ls_oc;
    cond[fpg_pkg::ST_HS_OCF] = oc_trip && cycle.hs_oc;
    cond[fpg_pkg::ST_OVF] = ovf;
    cond[fpg_pkg::ST_OVW] = overvoltage_warn_level;
    cond[fpg_pkg::ST_UVF] = uvf;
    cond[fpg_pkg::ST_UVW] = undervoltage_warn_level;
    cond[fpg_pkg::ST_LS_OCW] = cycle.cycle_end && cycle.ls_oc_warn;
    oc_cnt_next = oc_cnt_reg;
    if (cycle.cycle_end)
      oc_cnt_next = (oc_hit && !oc_trip) ? oc_cnt_reg + 2'h1 : 2'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencing state machine

  logic ls_hold_reg, ls_hold_next, hold_till_uv_reg, hold_till_uv_next;
  logic cool_ext_reg, cool_ext_next;
  logic [31:0] hic_cnt_reg, hic_cnt_next, hic_len;
  logic stop_ext, stop_ov, stop_oc, stop_uv;

  assign hic_len = 32'(fpg_pkg::HICCUP_RISES * fpg_pkg::CYC_PER_US) * {16'h0, ton_rise_reg};
  assign stop_ext = ext_otf && r_ot != fpg_pkg::RESP_IGNORE;
  assign stop_ov = ovf && r_ov != fpg_pkg::RESP_IGNORE;
  assign stop_oc = oc_trip && r_oc != fpg_pkg::RESP_IGNORE;
  assign stop_uv = uvf && r_uv != fpg_pkg::RESP_IGNORE;

  always_comb
  begin
    state_next = state_reg;
    ls_hold_next = ls_hold_reg;
    hold_till_uv_next = hold_till_uv_reg;
    cool_ext_next = cool_ext_reg;
    hic_cnt_next = 32'h0000_0000;
    // low side released once at UV limit
    if (ls_hold_reg && hold_till_uv_reg && sense.vout < uv_fault_reg)
      ls_hold_next = 1'b0;
    case (state_reg)
      S_OFF:
        if (on_ctrl)
          state_next = S_RISE;
      S_RISE, S_RUN:
      begin
        if (state_reg == S_RISE && soft_start_done)
          state_next = S_RUN;
        if (die_ot)
        begin
          state_next = S_COOL;
          cool_ext_next = 1'b0;
        end
        else if (stop_ext)
        begin
          state_next = r_ot == fpg_pkg::RESP_LATCH ? S_LATCH : S_COOL;
          cool_ext_next = 1'b1;
        end
        else if (stop_ov)
        begin
          state_next = r_ov == fpg_pkg::RESP_LATCH ? S_LATCH : S_HICCUP;
          ls_hold_next = 1'b1;
          hold_till_uv_next = ov_sel_reg;
        end
        else if (stop_oc)
          state_next = r_oc == fpg_pkg::RESP_LATCH ? S_LATCH : S_HICCUP;
        else if (stop_uv)
          state_next = r_uv == fpg_pkg::RESP_LATCH ? S_LATCH : S_HICCUP;
      end
      S_HICCUP:
      begin
        hic_cnt_next = hic_cnt_reg;
        if (!(ls_hold_reg && hold_till_uv_reg))
          hic_cnt_next = hic_cnt_reg + 32'h0000_0001;
        if (hic_cnt_reg >= hic_len)
        begin
          state_next = S_RISE;
          ls_hold_next = 1'b0;
        end
      end
      S_COOL:
        if (!die_ot && (!cool_ext_reg || cool_ok))
          state_next = S_RISE;
      // only clear or control toggle leaves
      S_LATCH:
        if (clear_pulse)
          state_next = S_OFF;
      default:
        state_next = S_OFF;
    endcase
    if (!on_ctrl)
      state_next = S_OFF;
    if (state_next == S_OFF)
      ls_hold_next = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power-good window and pull-down

  always_comb
  begin
    // hysteresis grows as loop scale shrinks
    hyst = (VW + 2)'({2'h0, fpg_pkg::HYST_BASE} << scale_reg);
    vx = {2'h0, sense.vout};
    win_hi = {2'h0, ov_warn_reg} - hyst;
    win_lo = {2'h0, uv_warn_reg} + hyst;
    pg_win_next = pg_win_reg;
    if (pg_win_reg && (overvoltage_warn_level || undervoltage_warn_level))
      pg_win_next = 1'b0;
    else if (!pg_win_reg && !win_hi[VW+1] && vx <= win_hi && vx >= win_lo)
      pg_win_next = 1'b1;
    // low outside window or before start-up ends
    pg_pull_next = state_reg != S_RUN || !pg_win_reg;
    if (die_ot || ovf || uvf || overvoltage_warn_level || undervoltage_warn_level || stop_oc)
      pg_pull_next = 1'b1;
    if ((ext_otf || ext_otw) && r_ot != fpg_pkg::RESP_IGNORE)
      pg_pull_next = 1'b1;
    if (cycle.ls_oc_warn && r_oc != fpg_pkg::RESP_IGNORE)
      pg_pull_next = 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= S_OFF;
      ls_hold_reg <= 1'b0;
      hold_till_uv_reg <= 1'b0;
      cool_ext_reg <= 1'b0;
      hic_cnt_reg <= 32'h0000_0000;
      oc_cnt_reg <= 2'h0;
      pg_win_reg <= 1'b0;
      pg_pull_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      ls_hold_reg <= ls_hold_next;
      hold_till_uv_reg <= hold_till_uv_next;
      cool_ext_reg <= cool_ext_next;
      hic_cnt_reg <= hic_cnt_next;
      oc_cnt_reg <= oc_cnt_next;
      pg_win_reg <= pg_win_next;
      pg_pull_reg <= pg_pull_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hs_fet_enable = state_reg == S_RISE || state_reg == S_RUN;
  assign ls_fet_enable = hs_fet_enable;
  assign ls_force_on = ls_hold_reg;
  assign soft_start_run = state_reg == S_RISE;
  assign high_side_current_limit_trim = trim_reg;
  assign power_good_out_o = 1'b0;
  assign power_good_out_oe = pg_pull_reg;
  assign smbalert_o = 1'b0;
  assign smbalert_oe = |(status_reg & ~mask_reg);

endmodule
`default_nettype wire

// >>> verilog/fpg_sync3.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module fpg_sync3 #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      // Single-cycle glitch past stage two is rejected
      always_comb
      begin
        out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;

endmodule
`default_nettype wire
